//--- pkg/cse_pkg.sv
// Constants and types shared by the charger status encoder
package cse_pkg;

	// ==========================================================
	// Charger state as seen by the status encoder
	typedef enum logic [2:0]
	{
		CSE_CHG_IDLE,
		CSE_CHG_DEAD,
		CSE_CHG_DEAD_PREQUAL,
		CSE_CHG_PREQUAL,
		CSE_CHG_FAST,
		CSE_CHG_DONE,
		CSE_CHG_TIMER_FAULT
	} cse_chg_state_t;

	// ==========================================================
	// Three-line codes, bit 2 is line A; 1 means released
	localparam logic [2:0] CSE_CODE3_COLD     = 3'h0;
	localparam logic [2:0] CSE_CODE3_OVERVOLT = 3'h1;
	localparam logic [2:0] CSE_CODE3_CHARGING = 3'h2;
	localparam logic [2:0] CSE_CODE3_HOT      = 3'h3;
	localparam logic [2:0] CSE_CODE3_DONE     = 3'h4;
	localparam logic [2:0] CSE_CODE3_ILLEGAL  = 3'h5;
	localparam logic [2:0] CSE_CODE3_TFAULT   = 3'h6;
	localparam logic [2:0] CSE_CODE3_IDLE     = 3'h7;

	// ==========================================================
	// Two-line codes, bit 1 is line A
	localparam logic [1:0] CSE_CODE2_ILLEGAL  = 2'h0;
	localparam logic [1:0] CSE_CODE2_CHARGING = 2'h1;
	localparam logic [1:0] CSE_CODE2_FAULT    = 2'h2;
	localparam logic [1:0] CSE_CODE2_IDLE     = 2'h3;

	// ==========================================================
	// Die temperature handling, degrees C and percent
	localparam logic [7:0] CSE_DIE_REGULATION_TEMP = 8'h73;
	localparam logic [7:0] CSE_DIE_SHUTDOWN_TEMP   = 8'h8c;
	localparam logic [7:0] CSE_DIE_HYSTERESIS      = 8'h0f;
	localparam logic [7:0] CSE_DIE_RESUME_TEMP     =
		CSE_DIE_SHUTDOWN_TEMP - CSE_DIE_HYSTERESIS;
	localparam logic [6:0] CSE_PCT_FULL            = 7'h64;
	localparam logic [6:0] CSE_PCT_FLOOR           = 7'h19;
	localparam logic [6:0] CSE_PCT_STEP            = 7'h05;

	// ==========================================================
	// Reset values
	localparam logic [2:0] CSE_LINES_RESET = 3'h7;
	localparam logic       CSE_OFF_RESET   = 1'h0;

endpackage

//--- pkg/cse_die_if.sv
// Die temperature link between the encoder and its thermal manager
`timescale 1ns/100ps
interface cse_die_if;
	import cse_pkg::*;

	logic [7:0] die_temp;
	logic       shutdown;
	logic [6:0] current_pct;

	modport mgr
	(
		input  die_temp,
		output shutdown,
		output current_pct
	);

	modport user
	(
		output die_temp,
		input  shutdown,
		input  current_pct
	);

endinterface

//--- hdl/cse_die_thermal.sv
// Die temperature foldback and thermal shutdown with hysteresis
`timescale 1ns/100ps
module cse_die_thermal
	import cse_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	cse_die_if.mgr    die
);

	// ==========================================================
	// State
	typedef struct packed
	{
		logic       shutdown;
		logic [6:0] current_pct;
	} cse_die_state_t;

	cse_die_state_t st;
	cse_die_state_t next_st;
	logic [15:0]    drop;

	// ==========================================================
	// Next state
	always_comb
	begin
		next_st = st;
		drop = 16'h0000;
		// Hysteresis keeps the charger from chattering at the limit
		if (die.die_temp > CSE_DIE_SHUTDOWN_TEMP)
			next_st.shutdown = 1'b1;
		else if (die.die_temp <= CSE_DIE_RESUME_TEMP)
			next_st.shutdown = 1'b0;
		if (die.die_temp <= CSE_DIE_REGULATION_TEMP)
			next_st.current_pct = CSE_PCT_FULL;
		else
		begin
			drop = 16'(die.die_temp - CSE_DIE_REGULATION_TEMP) * 16'(CSE_PCT_STEP);
			if (drop >= 16'(CSE_PCT_FULL - CSE_PCT_FLOOR))
				next_st.current_pct = CSE_PCT_FLOOR;
			else
				next_st.current_pct = CSE_PCT_FULL - drop[6:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st.shutdown <= CSE_OFF_RESET;
			st.current_pct <= CSE_PCT_FULL;
		end
		else
			st <= next_st;
	end

	assign die.shutdown = st.shutdown;
	assign die.current_pct = st.current_pct;

	// ==========================================================
	// Checks
	AST_SHDN_HYST: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(die.shutdown) |-> $past(die.die_temp) > CSE_DIE_SHUTDOWN_TEMP)
		else $error("Shutdown entered below the limit");
	AST_SHDN_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(die.shutdown) |-> $past(die.die_temp) <= CSE_DIE_RESUME_TEMP)
		else $error("Shutdown left before cooling by the hysteresis");
	AST_FOLDBACK_FLOOR: assert property (@(posedge clk) disable iff (!rst_n)
		(die.die_temp > CSE_DIE_REGULATION_TEMP) |=>
		die.current_pct >= CSE_PCT_FLOOR && die.current_pct < CSE_PCT_FULL)
		else $error("Foldback target outside its range");
	COV_SHDN: cover property (@(posedge clk) disable iff (!rst_n) $fell(die.shutdown));

endmodule

//--- hdl/cse_status_encoder.sv
// Charger status encoder: open-drain status lines and charger enables
`timescale 1ns/100ps
module cse_status_encoder
	import cse_pkg::*;
(
	input  wire logic           CLK_SYS,
	input  wire logic           RST_N,
	input  wire logic           THREE_LINE_MODE,
	input  wire cse_chg_state_t CHARGER_STATE,
	input  wire logic           CHARGE_ENABLE_N,
	input  wire logic           VIN_ABOVE_2V,
	input  wire logic           VIN_UNDERVOLT,
	input  wire logic           VIN_OVERVOLT,
	input  wire logic           VIN_HEADROOM_OK,
	input  wire logic           THERM_COLD,
	input  wire logic           THERM_HOT,
	input  wire logic [7:0]     DIE_TEMP,
	input  wire logic           STATUS_LINE_A_I,
	output wire logic           STATUS_LINE_A_O,
	output wire logic           STATUS_LINE_A_OE_N,
	input  wire logic           STATUS_LINE_B_I,
	output wire logic           STATUS_LINE_B_O,
	output wire logic           STATUS_LINE_B_OE_N,
	input  wire logic           STATUS_LINE_C_I,
	output wire logic           STATUS_LINE_C_O,
	output wire logic           STATUS_LINE_C_OE_N,
	output wire logic           GATE_DRIVE_SUPPLY_EN,
	output wire logic           CHARGER_RUN,
	output wire logic           TIMER_RUN,
	output wire logic           BLOCKS_RUN,
	output wire logic           THERMAL_SHUTDOWN,
	output wire logic [6:0]     CHARGE_CURRENT_PCT
);

	// ==========================================================
	// State
	typedef struct packed
	{
		logic [2:0] lines;
		logic       gate_drive_en;
		logic       charger_run;
		logic       timer_run;
	} cse_enc_state_t;

	cse_enc_state_t st;
	cse_enc_state_t next_st;
	logic           idle_any;
	logic           charging;
	logic           fault_any;
	logic [2:0]     code3;
	logic [1:0]     code2;

	cse_die_if die ();

	assign die.die_temp = DIE_TEMP;

	// ==========================================================
	// Die temperature manager
	cse_die_thermal u_die
	(
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.die   (die.mgr)
	);

	// ==========================================================
	// Condition decode
	always_comb
	begin
		idle_any = CHARGE_ENABLE_N | VIN_UNDERVOLT | !VIN_HEADROOM_OK | die.shutdown;
		unique case (CHARGER_STATE)
			CSE_CHG_DEAD, CSE_CHG_DEAD_PREQUAL, CSE_CHG_PREQUAL, CSE_CHG_FAST:
				charging = 1'b1;
			default:
				charging = 1'b0;
		endcase
		fault_any = VIN_OVERVOLT | THERM_COLD | THERM_HOT
			| (CHARGER_STATE == CSE_CHG_TIMER_FAULT);
	end

	// ==========================================================
	// Three-line code, idle first so one code always wins
	always_comb
	begin
		if (idle_any)
			code3 = CSE_CODE3_IDLE;
		else if (VIN_OVERVOLT)
			code3 = CSE_CODE3_OVERVOLT;
		else if (THERM_COLD)
			code3 = CSE_CODE3_COLD;
		else if (THERM_HOT)
			code3 = CSE_CODE3_HOT;
		else if (CHARGER_STATE == CSE_CHG_TIMER_FAULT)
			code3 = CSE_CODE3_TFAULT;
		else if (CHARGER_STATE == CSE_CHG_DONE)
			code3 = CSE_CODE3_DONE;
		else if (charging)
			code3 = CSE_CODE3_CHARGING;
		else
			code3 = CSE_CODE3_IDLE;
	end

	// ==========================================================
	// Two-line code, done counts as idle
	always_comb
	begin
		if (idle_any || CHARGER_STATE == CSE_CHG_DONE)
			code2 = CSE_CODE2_IDLE;
		else if (fault_any)
			code2 = CSE_CODE2_FAULT;
		else if (charging)
			code2 = CSE_CODE2_CHARGING;
		else
			code2 = CSE_CODE2_IDLE;
	end

	// ==========================================================
	// Next state
	always_comb
	begin
		next_st = st;
		if (THREE_LINE_MODE)
			next_st.lines = code3;
		else
			next_st.lines = {code2, !THERM_HOT};
		next_st.gate_drive_en = !CHARGE_ENABLE_N & VIN_ABOVE_2V & VIN_HEADROOM_OK;
		// Timers hold their count while out of range rather than reset
		next_st.timer_run = charging & !idle_any & !THERM_COLD & !THERM_HOT;
		next_st.charger_run = next_st.gate_drive_en & charging & !die.shutdown
			& !VIN_UNDERVOLT & !VIN_OVERVOLT & !THERM_COLD & !THERM_HOT;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RST_N)
		begin
			st.lines <= CSE_LINES_RESET;
			st.gate_drive_en <= CSE_OFF_RESET;
			st.charger_run <= CSE_OFF_RESET;
			st.timer_run <= CSE_OFF_RESET;
		end
		else
			st <= next_st;
	end

	// ==========================================================
	// Open-drain pins: drive low or let go, never drive high
	assign STATUS_LINE_A_O = 1'b0;
	assign STATUS_LINE_B_O = 1'b0;
	assign STATUS_LINE_C_O = 1'b0;
	assign STATUS_LINE_A_OE_N = st.lines[2];
	assign STATUS_LINE_B_OE_N = st.lines[1];
	assign STATUS_LINE_C_OE_N = st.lines[0];
	assign GATE_DRIVE_SUPPLY_EN = st.gate_drive_en;
	assign CHARGER_RUN = st.charger_run;
	assign TIMER_RUN = st.timer_run;
	assign BLOCKS_RUN = !die.shutdown;
	assign THERMAL_SHUTDOWN = die.shutdown;
	assign CHARGE_CURRENT_PCT = die.current_pct;

	// ==========================================================
	// Checks
	default clocking cse_cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	AST_COLD3: assert property (
		THREE_LINE_MODE && !idle_any && !VIN_OVERVOLT && THERM_COLD
		|=> {STATUS_LINE_A_OE_N, STATUS_LINE_B_OE_N, STATUS_LINE_C_OE_N} == 3'h0)
		else $error("Cold battery code not shown");

	AST_OVERVOLT3: assert property (
		THREE_LINE_MODE && !idle_any && VIN_OVERVOLT
		|=> {STATUS_LINE_A_OE_N, STATUS_LINE_B_OE_N, STATUS_LINE_C_OE_N} == 3'h1)
		else $error("Overvoltage code not shown");

	AST_DONE3: assert property (
		THREE_LINE_MODE && !idle_any && !fault_any && CHARGER_STATE == CSE_CHG_DONE
		|=> {STATUS_LINE_A_OE_N, STATUS_LINE_B_OE_N, STATUS_LINE_C_OE_N} == 3'h4)
		else $error("Done code not shown");

	AST_CHARGING3: assert property (
		THREE_LINE_MODE && !idle_any && !fault_any && charging
		|=> {STATUS_LINE_A_OE_N, STATUS_LINE_B_OE_N, STATUS_LINE_C_OE_N} == 3'h2)
		else $error("Charging code not shown");

	AST_HOT3: assert property (
		THREE_LINE_MODE && !idle_any && !VIN_OVERVOLT && !THERM_COLD && THERM_HOT
		|=> {STATUS_LINE_A_OE_N, STATUS_LINE_B_OE_N, STATUS_LINE_C_OE_N} == 3'h3)
		else $error("Hot battery code not shown");

	AST_NO_ILLEGAL3: assert property (
		$past(THREE_LINE_MODE)
		|-> {STATUS_LINE_A_OE_N, STATUS_LINE_B_OE_N, STATUS_LINE_C_OE_N} != 3'h5)
		else $error("Undefined three-line code driven");

	AST_IDLE3: assert property (
		THREE_LINE_MODE && idle_any
		|=> STATUS_LINE_A_OE_N && STATUS_LINE_B_OE_N && STATUS_LINE_C_OE_N)
		else $error("Lines not released while idle");

	AST_CHARGING2: assert property (
		!THREE_LINE_MODE && !idle_any && !fault_any && charging
		|=> !STATUS_LINE_A_OE_N && STATUS_LINE_B_OE_N)
		else $error("Two-line charging code not shown");

	AST_FAULT2: assert property (
		!THREE_LINE_MODE && !idle_any && CHARGER_STATE != CSE_CHG_DONE && fault_any
		|=> STATUS_LINE_A_OE_N && !STATUS_LINE_B_OE_N)
		else $error("Two-line fault code not shown");

	AST_IDLE2: assert property (
		!THREE_LINE_MODE && (idle_any || CHARGER_STATE == CSE_CHG_DONE)
		|=> STATUS_LINE_A_OE_N && STATUS_LINE_B_OE_N)
		else $error("Two-line idle code not shown");

	AST_NO_BOTH_LOW2: assert property (
		$past(!THREE_LINE_MODE) |-> STATUS_LINE_A_OE_N || STATUS_LINE_B_OE_N)
		else $error("Both two-line outputs low");

	AST_HOT_LINE2: assert property (
		!THREE_LINE_MODE |=> STATUS_LINE_C_OE_N == !$past(THERM_HOT))
		else $error("Hot line does not follow battery temperature");

	AST_OPEN_DRAIN: assert property (
		!STATUS_LINE_A_O && !STATUS_LINE_B_O && !STATUS_LINE_C_O)
		else $error("Status line driven high");

	AST_SHDN_STOP: assert property (
		die.shutdown |=> !CHARGER_RUN)
		else $error("Charger running in thermal shutdown");

	AST_GATE_DRIVE: assert property (
		GATE_DRIVE_SUPPLY_EN
		|-> $past(!CHARGE_ENABLE_N && VIN_ABOVE_2V && VIN_HEADROOM_OK))
		else $error("Gate-drive supply on without its conditions");

	AST_TIMER_FREEZE: assert property (
		(THERM_COLD || THERM_HOT) |=> !TIMER_RUN && !CHARGER_RUN)
		else $error("Charging or timers active out of range");

	AST_TFAULT3: assert property (
		THREE_LINE_MODE && !idle_any && !VIN_OVERVOLT && !THERM_COLD && !THERM_HOT
		&& CHARGER_STATE == CSE_CHG_TIMER_FAULT
		|=> {STATUS_LINE_A_OE_N, STATUS_LINE_B_OE_N, STATUS_LINE_C_OE_N} == 3'h6)
		else $error("Timer fault code not shown");

	AST_SHDN_LINES: assert property (
		die.shutdown |=> STATUS_LINE_A_OE_N && STATUS_LINE_B_OE_N)
		else $error("Status lines held during thermal shutdown");

	AST_CHARGER_RUN: assert property (
		CHARGER_RUN |-> GATE_DRIVE_SUPPLY_EN && $past(charging && !die.shutdown))
		else $error("Charger running without its conditions");

	AST_PCT_FULL: assert property (
		DIE_TEMP <= CSE_DIE_REGULATION_TEMP |=> CHARGE_CURRENT_PCT == CSE_PCT_FULL)
		else $error("Current target folded back below regulation temperature");

	AST_PCT_FALLS: assert property (
		DIE_TEMP > $past(DIE_TEMP) |=> CHARGE_CURRENT_PCT <= $past(CHARGE_CURRENT_PCT))
		else $error("Current target rose while die heated");

	AST_GATE_ON: assert property (
		!CHARGE_ENABLE_N && VIN_ABOVE_2V && VIN_HEADROOM_OK |=> GATE_DRIVE_SUPPLY_EN)
		else $error("Gate-drive supply off with its conditions met");

	AST_TIMER_RESUME: assert property (
		charging && !idle_any && !THERM_COLD && !THERM_HOT |=> TIMER_RUN)
		else $error("Timers not counting in range");

	AST_TIMER_STATES: assert property (
		TIMER_RUN |-> $past(charging))
		else $error("Timers counting outside a charging state");

	COV_CHARGING3: cover property (
		THREE_LINE_MODE && STATUS_LINE_B_OE_N && !STATUS_LINE_C_OE_N);
	COV_FAULT2: cover property (
		!THREE_LINE_MODE && STATUS_LINE_A_OE_N && !STATUS_LINE_B_OE_N);
	COV_HOT2: cover property (!THREE_LINE_MODE && !STATUS_LINE_C_OE_N);
	COV_GATE: cover property ($rose(GATE_DRIVE_SUPPLY_EN));

endmodule

//--- sim/cse_host_model.sv
// Host side of the status lines: pull-ups and a deglitched code reader
`timescale 1ns/100ps
module cse_host_model
	import cse_pkg::*;
#(
	parameter int STABLE_CYCLES = 3
)
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] line_o,
	input  wire logic [2:0] line_oe_n,
	output logic      [2:0] line_level,
	output logic      [2:0] code
);
	logic [2:0] last;
	int         same;

	// ==========================================================
	// Pull-up wins whenever the encoder lets go of a line
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			line_level[i] = line_oe_n[i] ? 1'b1 : line_o[i];
	end

	// ==========================================================
	// Lines may move apart on one change, so trust only a still code
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			last <= 3'h7;
			same <= 0;
			code <= 3'h7;
		end
		else
		begin
			last <= line_level;
			same <= (line_level != last) ? 0 : same + 1;
			if (same >= STABLE_CYCLES)
				code <= last;
		end
	end
endmodule

//--- sim/test_charger_status_encoder.sv
// Self-checking bench for the charger status encoder with a host reader
`timescale 1ns/100ps
module test_charger_status_encoder;
	import cse_pkg::*;

	logic           clk   = 1'b0;
	logic           rst_n = 1'b0;
	logic           mode  = 1'b1;
	cse_chg_state_t state = CSE_CHG_IDLE;
	logic           ena_n = 1'b1;
	logic           a2v   = 1'b1;
	logic           uv    = 1'b0;
	logic           ov    = 1'b0;
	logic           hr    = 1'b1;
	logic           cold  = 1'b0;
	logic           hot   = 1'b0;
	logic [7:0]     temp  = 8'h19;
	logic [2:0]     lo, oe_n, level, host_code, e_lines, c3;
	logic [1:0]     c2;
	logic           gate, run, tim, blk, shut, e_gate, e_run, e_tim, m_shut, chg, idle;
	logic [6:0]     pct, e_pct;
	int             num_errors, check_count, seed, t, st, p;

	cse_status_encoder cse_status_encoder_i (.CLK_SYS(clk), .RST_N(rst_n),
		.THREE_LINE_MODE(mode), .CHARGER_STATE(state), .CHARGE_ENABLE_N(ena_n),
		.VIN_ABOVE_2V(a2v), .VIN_UNDERVOLT(uv), .VIN_OVERVOLT(ov), .VIN_HEADROOM_OK(hr),
		.THERM_COLD(cold), .THERM_HOT(hot), .DIE_TEMP(temp),
		.STATUS_LINE_A_I(level[2]), .STATUS_LINE_A_O(lo[2]), .STATUS_LINE_A_OE_N(oe_n[2]),
		.STATUS_LINE_B_I(level[1]), .STATUS_LINE_B_O(lo[1]), .STATUS_LINE_B_OE_N(oe_n[1]),
		.STATUS_LINE_C_I(level[0]), .STATUS_LINE_C_O(lo[0]), .STATUS_LINE_C_OE_N(oe_n[0]),
		.GATE_DRIVE_SUPPLY_EN(gate), .CHARGER_RUN(run), .TIMER_RUN(tim), .BLOCKS_RUN(blk),
		.THERMAL_SHUTDOWN(shut), .CHARGE_CURRENT_PCT(pct));

	cse_host_model cse_host_model_i (.clk(clk), .rst_n(rst_n), .line_o(lo),
		.line_oe_n(oe_n), .line_level(level), .code(host_code));

	always #20 clk = ~clk;

	// ==========================================================
	// Reference model, evaluated at every sampling edge
	always @(posedge clk)
	begin
		st = int'(state);
		t = int'(temp);
		chg = (st >= 1) && (st <= 4);
		// Codes and run flags see the shutdown flag as it stood before this edge
		idle = ena_n || uv || !hr || m_shut;
		c3 = idle ? 3'h7 : ov ? 3'h1 : cold ? 3'h0 : hot ? 3'h3 :
			(st == 6) ? 3'h6 : (st == 5) ? 3'h4 : chg ? 3'h2 : 3'h7;
		c2 = (idle || st == 5) ? 2'h3 : (ov || cold || hot || st == 6) ? 2'h2 :
			chg ? 2'h1 : 2'h3;
		e_lines = !rst_n ? 3'h7 : mode ? c3 : {c2, !hot};
		e_gate = rst_n && !ena_n && a2v && hr;
		e_run = e_gate && chg && !m_shut && !uv && !ov && !cold && !hot;
		e_tim = rst_n && chg && !idle && !cold && !hot;
		m_shut = !rst_n ? 1'b0 : (m_shut ? (t > 125) : (t > 140));
		p = 100 - 5 * (t - 115);
		e_pct = (!rst_n || t <= 115) ? 7'h64 : (p < 25) ? 7'h19 : 7'(p);
	end

	// ==========================================================
	// Comparisons
	task automatic fail(input string what, input logic [6:0] got, input logic [6:0] exp);
		num_errors++;
		$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
	endtask

	task automatic chk_lines(input logic [2:0] got, input logic [2:0] exp);
		check_count++;
		if (got !== exp)
			fail("lines", 7'(got), 7'(exp));
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp)
			fail("flag", 7'(got), 7'(exp));
	endtask

	task automatic chk_pct(input logic [6:0] got, input logic [6:0] exp);
		check_count++;
		if (got !== exp)
			fail("percent", got, exp);
	endtask

	always @(negedge clk)
	begin
		chk_lines(oe_n, e_lines);
		chk_lines(lo, 3'h0);
		chk_flag(gate, e_gate);
		chk_flag(run, e_run);
		chk_flag(tim, e_tim);
		chk_flag(shut, m_shut);
		chk_flag(blk, !m_shut);
		chk_pct(pct, e_pct);
	end

	// ==========================================================
	// Stimulus and closing
	task automatic rnd_inputs();
		logic [31:0] r;
		r = $random(seed);
		{ena_n, uv, ov, cold, hot} = {r[2:0] == 0, r[5:3] == 0, r[8:6] == 0,
			r[11:9] == 0, r[14:12] == 0};
		hr = r[17:15] != 0;
		a2v = r[20:18] != 0;
		mode = r[21];
		temp = 8'(100 + r[31:26]);
		state = cse_chg_state_t'(3'($unsigned($random(seed)) % 7));
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		#(40 * 3000);
		fail("watchdog", 7'h0, 7'h0);
		stop_test();
	end

	initial
	begin
		seed = 32'h1728;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		$display("test reset done");
		// Every state against every single condition except die shutdown, both variants
		for (int m = 0; m < 2; m++)
			for (int s = 0; s < 7; s++)
				for (int k = 0; k < 8; k++)
				begin
					@(negedge clk);
					mode = m[0];
					state = cse_chg_state_t'(s);
					{ena_n, uv, ov, hr} = {k == 1, k == 2, k == 3, k != 4};
					{cold, hot, a2v} = {k == 5, k == 6, k != 7};
				end
		$display("test sweep done");
		// Die heats past shutdown and cools back through the hysteresis band
		@(negedge clk);
		state = CSE_CHG_FAST;
		{ena_n, uv, ov, hr, cold, hot, a2v} = 7'h09;
		for (int i = 0; i < 102; i++)
		begin
			@(negedge clk);
			temp = 8'(i <= 50 ? 100 + i : 201 - i);
		end
		$display("test die temperature done");
		// Overlapping conditions, where priority decides the code
		repeat (400)
		begin
			@(negedge clk);
			rnd_inputs();
		end
		$display("test random done");
		// Host reads a settled code
		repeat (6)
		begin
			@(negedge clk);
			rnd_inputs();
			repeat (7) @(negedge clk);
			chk_lines(host_code, e_lines);
		end
		$display("test host read done");
		stop_test();
	end
endmodule
